// ==== rtl/afce_pkg.sv ====
// package: opcodes, flag layout, cycle counts and reset values of the execution unit
// Operation
// - add and add-with-carry write Rd+src_reg(+C) in one cycle, flags ZCNVH
// - subtract-with-carry writes Rd-src_reg-C in one cycle, flags ZCNVH
// - subtract immediate writes Rd-K in one cycle, flags Z C N V H
// - subtract immediate with carry writes Rd-K-C in one cycle, flags ZCNVH
// - word add immediate adds K to the register pair in two cycles, flags ZCNVS
// - word subtract immediate subtracts K from the pair in two cycles, flags ZCNVS
// - AND with register or constant in one cycle, flags Z N V only
// - OR with register or constant in one cycle, flags Z N V only
// - set-bits ORs a constant mask into Rd in one cycle, flags Z N V
// - clear-bits ANDs Rd with the inverted mask in one cycle, flags Z N V
// - test ANDs Rd with itself in one cycle, flags Z N V
// - integer multiplies put the 16-bit product in R1:R0 in two cycles, flags Z C
// - fractional multiplies put product shifted left one in R1:R0, two cycles, flags Z C
// - jumps: pointer and relative take two cycles, absolute takes three
// - calls push return address: pointer and relative three cycles, absolute four; return four
package afce_pkg;
	typedef enum logic [5:0] {
		op_add, op_add_carry, op_word_add_imm, op_sub, op_sub_imm, op_sub_regs_carry,
		op_sub_imm_carry, op_word_sub_imm, op_and_regs, op_bitwise_conj_imm, op_or_regs,
		op_bitwise_disj_imm, op_bitwise_xor_regs, op_ones_complement, op_twos_complement,
		op_set_mask_bits, op_clear_mask_bits, op_increment_reg, op_decrement_reg, op_test_reg,
		op_clear_reg, op_set_reg_ones, op_mult_unsigned, op_mult_signed, op_mult_signed_unsigned,
		op_frac_mult_unsigned, op_frac_mult_signed, op_frac_mult_mixed, op_relative_jump,
		op_pointer_jump, op_absolute_jump, op_relative_call, op_pointer_call, op_absolute_call,
		op_subroutine_return, op_interrupt_return
	} afce_op_e;

	// =============================================================
	// status flag positions and update masks
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_I = 7;
	localparam logic [7:0] MASK_NONE = 8'h00;
	localparam logic [7:0] MASK_ZCNVH = 8'h2f;
	localparam logic [7:0] MASK_ZCNVS = 8'h1f;
	localparam logic [7:0] MASK_ZCNV = 8'h0f;
	localparam logic [7:0] MASK_ZNV = 8'h0e;
	localparam logic [7:0] MASK_ZC = 8'h03;

	// =============================================================
	// constants, reset values and cycle counts
	localparam logic [7:0] ALL_ONES = 8'hff;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [7:0] INC_OVF = 8'h80;
	localparam logic [7:0] DEC_OVF = 8'h7f;
	localparam logic [7:0] SREG_RESET = 8'h00;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] PC_STEP = 16'h0001;
	localparam logic [15:0] PC_STEP_LONG = 16'h0002;
	localparam logic [2:0] CYC_ONE = 3'h1;
	localparam logic [2:0] CYC_TWO = 3'h2;
	localparam logic [2:0] CYC_THREE = 3'h3;
	localparam logic [2:0] CYC_FOUR = 3'h4;

	function automatic logic [2:0] op_cycles(input afce_op_e op);
		case (op)
			op_word_add_imm, op_word_sub_imm, op_mult_unsigned, op_mult_signed,
			op_mult_signed_unsigned, op_frac_mult_unsigned, op_frac_mult_signed,
			op_frac_mult_mixed, op_relative_jump, op_pointer_jump: op_cycles = CYC_TWO;
			op_absolute_jump, op_relative_call, op_pointer_call: op_cycles = CYC_THREE;
			op_absolute_call, op_subroutine_return, op_interrupt_return: op_cycles = CYC_FOUR;
			default: op_cycles = CYC_ONE;
		endcase
	endfunction
endpackage

// ==== rtl/afce_alu.sv ====
// combinational result and flag generation for one decoded operation
`timescale 1ns/1ns
module afce_alu (
	input wire afce_pkg::afce_op_e op, // decoded operation
	input wire logic [7:0] a, // destination register value
	input wire logic [7:0] a_hi, // high register of a word pair
	input wire logic [7:0] b, // source register value
	input wire logic [7:0] imm, // constant operand
	input wire logic [7:0] sreg, // current status flags
	output logic [15:0] res, // result word
	output logic [7:0] flags, // new flag values
	output logic [7:0] mask // flags to update
);
	logic [7:0] x, y, r8;
	logic ci, is_sub, sa, sb;
	logic [8:0] sum9, dif9;
	logic [4:0] sum5, dif5;
	logic [15:0] wsum, wdif, p16;
	logic [17:0] prod;

	// =============================================================
	// shared 8-bit adder operand selection
	always_comb begin
		x = a;
		y = b;
		ci = 1'b0;
		is_sub = 1'b0;
		case (op)
			afce_pkg::op_add_carry: ci = sreg[afce_pkg::FLAG_C];
			afce_pkg::op_sub: is_sub = 1'b1;
			afce_pkg::op_sub_regs_carry: begin
				is_sub = 1'b1;
				ci = sreg[afce_pkg::FLAG_C];
			end
			afce_pkg::op_sub_imm: begin
				y = imm;
				is_sub = 1'b1;
			end
			afce_pkg::op_sub_imm_carry: begin
				y = imm;
				is_sub = 1'b1;
				ci = sreg[afce_pkg::FLAG_C];
			end
			afce_pkg::op_twos_complement: begin
				x = afce_pkg::BYTE_ZERO;
				y = a;
				is_sub = 1'b1;
			end
			afce_pkg::op_increment_reg: y = afce_pkg::BYTE_ONE;
			afce_pkg::op_decrement_reg: begin
				y = afce_pkg::BYTE_ONE;
				is_sub = 1'b1;
			end
			default: ;
		endcase
	end

	assign sum9 = {1'b0, x} + {1'b0, y} + {8'h00, ci};
	assign dif9 = {1'b0, x} - {1'b0, y} - {8'h00, ci};
	assign sum5 = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
	assign dif5 = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ci};
	assign r8 = is_sub ? dif9[7:0] : sum9[7:0];
	assign wsum = {a_hi, a} + {8'h00, imm};
	assign wdif = {a_hi, a} - {8'h00, imm};
	assign sa = op inside {afce_pkg::op_mult_signed, afce_pkg::op_mult_signed_unsigned,
		afce_pkg::op_frac_mult_signed, afce_pkg::op_frac_mult_mixed};
	assign sb = op inside {afce_pkg::op_mult_signed, afce_pkg::op_frac_mult_signed};
	assign prod = $signed({sa & a[7], a}) * $signed({sb & b[7], b});
	assign p16 = prod[15:0];

	// =============================================================
	// result and flag selection
	always_comb begin
		res = {afce_pkg::BYTE_ZERO, r8};
		flags = sreg;
		mask = afce_pkg::MASK_ZCNVH;
		flags[afce_pkg::FLAG_Z] = (r8 == afce_pkg::BYTE_ZERO);
		flags[afce_pkg::FLAG_N] = r8[7];
		flags[afce_pkg::FLAG_C] = is_sub ? dif9[8] : sum9[8];
		flags[afce_pkg::FLAG_H] = is_sub ? dif5[4] : sum5[4];
		flags[afce_pkg::FLAG_V] = is_sub ? ((x[7] & ~y[7] & ~r8[7]) | (~x[7] & y[7] & r8[7]))
			: ((x[7] & y[7] & ~r8[7]) | (~x[7] & ~y[7] & r8[7]));
		case (op)
			afce_pkg::op_sub_regs_carry, afce_pkg::op_sub_imm_carry:
				flags[afce_pkg::FLAG_Z] = (r8 == afce_pkg::BYTE_ZERO) & sreg[afce_pkg::FLAG_Z];
			afce_pkg::op_increment_reg, afce_pkg::op_decrement_reg: begin
				mask = afce_pkg::MASK_ZNV;
				flags[afce_pkg::FLAG_V] = (r8 == (is_sub ? afce_pkg::DEC_OVF : afce_pkg::INC_OVF));
			end
			afce_pkg::op_ones_complement: begin
				res = {afce_pkg::BYTE_ZERO, afce_pkg::ALL_ONES - a};
				mask = afce_pkg::MASK_ZCNV;
				flags[afce_pkg::FLAG_C] = 1'b1;
				flags[afce_pkg::FLAG_V] = 1'b0;
				flags[afce_pkg::FLAG_Z] = (a == afce_pkg::ALL_ONES);
				flags[afce_pkg::FLAG_N] = ~a[7];
			end
			afce_pkg::op_word_add_imm, afce_pkg::op_word_sub_imm: begin
				res = (op == afce_pkg::op_word_add_imm) ? wsum : wdif;
				mask = afce_pkg::MASK_ZCNVS;
				flags[afce_pkg::FLAG_Z] = (res == 16'h0000);
				flags[afce_pkg::FLAG_N] = res[15];
				flags[afce_pkg::FLAG_V] = (op == afce_pkg::op_word_add_imm) ? (~a_hi[7] & res[15])
					: (a_hi[7] & ~res[15]);
				flags[afce_pkg::FLAG_C] = (op == afce_pkg::op_word_add_imm) ? (a_hi[7] & ~res[15])
					: (~a_hi[7] & res[15]);
				flags[afce_pkg::FLAG_S] = res[15] ^ flags[afce_pkg::FLAG_V];
			end
			afce_pkg::op_and_regs, afce_pkg::op_bitwise_conj_imm, afce_pkg::op_or_regs,
			afce_pkg::op_bitwise_disj_imm, afce_pkg::op_bitwise_xor_regs, afce_pkg::op_set_mask_bits,
			afce_pkg::op_clear_mask_bits, afce_pkg::op_test_reg, afce_pkg::op_clear_reg: begin
				case (op)
					afce_pkg::op_and_regs: res[7:0] = a & b;
					afce_pkg::op_bitwise_conj_imm: res[7:0] = a & imm;
					afce_pkg::op_or_regs: res[7:0] = a | b;
					afce_pkg::op_bitwise_disj_imm, afce_pkg::op_set_mask_bits:
						res[7:0] = a | imm;
					afce_pkg::op_clear_mask_bits: res[7:0] = a & (afce_pkg::ALL_ONES - imm);
					afce_pkg::op_test_reg: res[7:0] = a & a;
					afce_pkg::op_clear_reg: res[7:0] = a ^ a;
					default: res[7:0] = a ^ b;
				endcase
				mask = afce_pkg::MASK_ZNV;
				flags[afce_pkg::FLAG_Z] = (res[7:0] == afce_pkg::BYTE_ZERO);
				flags[afce_pkg::FLAG_N] = res[7];
				flags[afce_pkg::FLAG_V] = 1'b0;
			end
			afce_pkg::op_set_reg_ones: begin
				res = {afce_pkg::BYTE_ZERO, afce_pkg::ALL_ONES};
				mask = afce_pkg::MASK_NONE;
			end
			afce_pkg::op_mult_unsigned, afce_pkg::op_mult_signed, afce_pkg::op_mult_signed_unsigned,
			afce_pkg::op_frac_mult_unsigned, afce_pkg::op_frac_mult_signed,
			afce_pkg::op_frac_mult_mixed: begin
				res = sa & ~sb & (op == afce_pkg::op_frac_mult_mixed) | op inside {
					afce_pkg::op_frac_mult_unsigned, afce_pkg::op_frac_mult_signed}
					? {p16[14:0], 1'b0} : p16;
				mask = afce_pkg::MASK_ZC;
				flags[afce_pkg::FLAG_C] = p16[15];
				flags[afce_pkg::FLAG_Z] = (res == 16'h0000);
			end
			afce_pkg::op_relative_jump, afce_pkg::op_pointer_jump, afce_pkg::op_absolute_jump,
			afce_pkg::op_relative_call, afce_pkg::op_pointer_call, afce_pkg::op_absolute_call,
			afce_pkg::op_subroutine_return, afce_pkg::op_interrupt_return: mask = afce_pkg::MASK_NONE;
			default: ;
		endcase
	end
endmodule

// ==== rtl/afce_exec.sv ====
// execution unit: sequences one decoded operation, writes back results, flags and counter
`timescale 1ns/1ns
module afce_exec (
	input wire logic clk, // core clock
	input wire logic rst_b, // synchronous reset, active low
	input wire logic op_valid, // decoded operation offered
	input wire afce_pkg::afce_op_e op_code, // decoded operation
	input wire logic [7:0] op_dst, // destination register value
	input wire logic [7:0] op_dst_hi, // high register of word pair
	input wire logic [7:0] op_src, // source register value
	input wire logic [7:0] op_imm, // constant operand
	input wire logic [15:0] op_addr, // absolute target or signed offset
	input wire logic [15:0] z_ptr, // pointer register pair
	input wire logic [15:0] stack_rdata, // popped return address
	output logic busy, // operation in progress
	output logic done, // operation finished pulse
	output logic wr_en, // register write-back pulse
	output logic wr_pair, // write-back covers two registers
	output logic wr_r10, // write-back goes to R1:R0
	output logic [15:0] wr_data, // write-back data
	output logic [7:0] sreg, // status flags
	output logic [15:0] pc, // program counter
	output logic stack_push, // push pulse
	output logic [15:0] stack_wdata, // pushed return address
	output logic stack_pop // pop pulse
);
	typedef enum logic {ST_IDLE = 1'b0, ST_EXEC = 1'b1} afce_st_e;
	typedef struct packed {
		afce_st_e st;
		logic [2:0] cnt;
		logic busy;
		logic done;
		logic wr_en;
		logic wr_pair;
		logic wr_r10;
		logic [15:0] wr_data;
		logic [7:0] sreg;
		logic [15:0] pc;
		logic push;
		logic [15:0] push_data;
		logic pop;
		logic p_wr;
		logic p_pair;
		logic p_r10;
		logic p_ret;
		logic [15:0] p_data;
		logic [7:0] p_sreg;
		logic [15:0] p_pc;
	} afce_exec_s;

	afce_exec_s s_ff, nxt_s;
	logic [15:0] alu_res;
	logic [7:0] alu_flags, alu_mask;
	logic [2:0] cyc;
	logic fin;

	afce_alu u_alu (
		.op(op_code),
		.a(op_dst),
		.a_hi(op_dst_hi),
		.b(op_src),
		.imm(op_imm),
		.sreg(s_ff.sreg),
		.res(alu_res),
		.flags(alu_flags),
		.mask(alu_mask)
	);

	assign cyc = afce_pkg::op_cycles(op_code);

	// =============================================================
	// next state
	always_comb begin
		nxt_s = s_ff;
		nxt_s.done = 1'b0;
		nxt_s.wr_en = 1'b0;
		nxt_s.push = 1'b0;
		nxt_s.pop = 1'b0;
		fin = 1'b0;
		unique case (s_ff.st)
			ST_IDLE: begin
				if (op_valid) begin
					nxt_s.p_data = alu_res;
					nxt_s.p_sreg = (s_ff.sreg & ~alu_mask) | (alu_flags & alu_mask);
					nxt_s.p_wr = (alu_mask != afce_pkg::MASK_NONE)
						|| (op_code == afce_pkg::op_set_reg_ones);
					nxt_s.p_pair = op_code inside {afce_pkg::op_word_add_imm, afce_pkg::op_word_sub_imm}
						|| (alu_mask == afce_pkg::MASK_ZC);
					nxt_s.p_r10 = (alu_mask == afce_pkg::MASK_ZC);
					nxt_s.p_ret = 1'b0;
					nxt_s.p_pc = s_ff.pc + afce_pkg::PC_STEP;
					case (op_code)
						afce_pkg::op_relative_jump, afce_pkg::op_relative_call:
							nxt_s.p_pc = s_ff.pc + op_addr + afce_pkg::PC_STEP;
						afce_pkg::op_pointer_jump, afce_pkg::op_pointer_call:
							nxt_s.p_pc = z_ptr;
						afce_pkg::op_absolute_jump, afce_pkg::op_absolute_call:
							nxt_s.p_pc = op_addr;
						afce_pkg::op_subroutine_return: begin
							nxt_s.p_ret = 1'b1;
							nxt_s.pop = 1'b1;
						end
						afce_pkg::op_interrupt_return: begin
							nxt_s.p_ret = 1'b1;
							nxt_s.pop = 1'b1;
							nxt_s.p_sreg[afce_pkg::FLAG_I] = 1'b1;
						end
						default: ;
					endcase
					if (op_code inside {afce_pkg::op_relative_call, afce_pkg::op_pointer_call,
						afce_pkg::op_absolute_call}) begin
						nxt_s.push = 1'b1;
						nxt_s.push_data = s_ff.pc + ((op_code == afce_pkg::op_absolute_call)
							? afce_pkg::PC_STEP_LONG : afce_pkg::PC_STEP);
					end
					if (cyc == afce_pkg::CYC_ONE) begin
						fin = 1'b1;
					end else begin
						nxt_s.st = ST_EXEC;
						nxt_s.cnt = cyc - afce_pkg::CYC_ONE;
					end
				end
			end
			ST_EXEC: begin
				nxt_s.cnt = s_ff.cnt - afce_pkg::CYC_ONE;
				fin = (s_ff.cnt == afce_pkg::CYC_ONE);
			end
		endcase
		if (fin) begin
			nxt_s.st = ST_IDLE;
			nxt_s.done = 1'b1;
			nxt_s.wr_en = nxt_s.p_wr;
			nxt_s.wr_pair = nxt_s.p_pair;
			nxt_s.wr_r10 = nxt_s.p_r10;
			nxt_s.wr_data = nxt_s.p_data;
			nxt_s.sreg = nxt_s.p_sreg;
			nxt_s.pc = nxt_s.p_ret ? stack_rdata : nxt_s.p_pc;
		end
		nxt_s.busy = (nxt_s.st == ST_EXEC);
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_ff <= '0;
			s_ff.sreg <= afce_pkg::SREG_RESET;
			s_ff.pc <= afce_pkg::PC_RESET;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign busy = s_ff.busy;
	assign done = s_ff.done;
	assign wr_en = s_ff.wr_en;
	assign wr_pair = s_ff.wr_pair;
	assign wr_r10 = s_ff.wr_r10;
	assign wr_data = s_ff.wr_data;
	assign sreg = s_ff.sreg;
	assign pc = s_ff.pc;
	assign stack_push = s_ff.push;
	assign stack_wdata = s_ff.push_data;
	assign stack_pop = s_ff.pop;

	// =============================================================
	// assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	logic go;
	assign go = op_valid && !busy;

	add_carry_result_a: assert property (go && op_code == afce_pkg::op_add_carry |=>
		done && wr_en && wr_data[7:0] == 8'($past(op_dst) + $past(op_src) + $past(sreg[0])))
		else $error("add with carry result wrong");
	sub_carry_result_a: assert property (go && op_code == afce_pkg::op_sub_regs_carry |=>
		done && wr_data[7:0] == 8'($past(op_dst) - $past(op_src) - $past(sreg[0])))
		else $error("subtract with carry result wrong");
	sub_imm_borrow_a: assert property (go && op_code == afce_pkg::op_sub_imm |=>
		sreg[afce_pkg::FLAG_C] == ($past(op_imm) > $past(op_dst)))
		else $error("subtract immediate borrow wrong");
	sub_imm_carry_a: assert property (go && op_code == afce_pkg::op_sub_imm_carry |=>
		wr_data[7:0] == 8'($past(op_dst) - $past(op_imm) - $past(sreg[0])))
		else $error("subtract immediate with carry wrong");
	word_add_time_a: assert property (go && op_code == afce_pkg::op_word_add_imm |=>
		busy && !done ##1 done && wr_pair
		&& wr_data == 16'($past({op_dst_hi, op_dst}, 2) + {8'h00, $past(op_imm, 2)}))
		else $error("word add timing or result wrong");
	word_sub_result_a: assert property (go && op_code == afce_pkg::op_word_sub_imm |->
		##2 done && wr_data == 16'($past({op_dst_hi, op_dst}, 2) - {8'h00, $past(op_imm, 2)}))
		else $error("word subtract result wrong");
	logic_keeps_carry_a: assert property (go &&
		op_code inside {afce_pkg::op_and_regs,
		afce_pkg::op_bitwise_conj_imm, afce_pkg::op_or_regs, afce_pkg::op_bitwise_disj_imm,
		afce_pkg::op_set_mask_bits, afce_pkg::op_clear_mask_bits, afce_pkg::op_test_reg} |=>
		done && sreg[afce_pkg::FLAG_C] == $past(sreg[afce_pkg::FLAG_C]) && !sreg[afce_pkg::FLAG_V])
		else $error("logic operation touched carry or overflow");
	complement_result_a: assert property (go && op_code == afce_pkg::op_ones_complement
		|=> wr_data[7:0] == ~$past(op_dst) && sreg[afce_pkg::FLAG_C])
		else $error("one's complement wrong");
	signed_mult_a: assert property (go && op_code == afce_pkg::op_mult_signed |=>
		!done ##1 done && wr_r10 && wr_data == 16'({{8{$past(op_dst[7], 2)}}, $past(op_dst, 2)}
		* {{8{$past(op_src[7], 2)}}, $past(op_src, 2)}))
		else $error("signed multiply wrong");
	frac_mult_a: assert property (go && op_code == afce_pkg::op_frac_mult_unsigned |->
		##2 done && wr_data == 16'(({8'h00, $past(op_dst, 2)} * {8'h00, $past(op_src, 2)}) << 1))
		else $error("fractional multiply wrong");
	pointer_jump_a: assert property (go && op_code == afce_pkg::op_pointer_jump |->
		##2 done && pc == $past(z_ptr, 2))
		else $error("pointer jump wrong");
	absolute_call_a: assert property (go && op_code == afce_pkg::op_absolute_call |=>
		stack_push && !done ##3 done && pc == $past(op_addr, 4))
		else $error("absolute call wrong");
	interrupt_return_enable_a: assert property (go && op_code == afce_pkg::op_interrupt_return |->
		##4 done && sreg[afce_pkg::FLAG_I] && pc == $past(stack_rdata))
		else $error("interrupt return wrong");
	set_ones_flags_a: assert property (go && op_code == afce_pkg::op_set_reg_ones |=>
		sreg == $past(sreg) && wr_data[7:0] == 8'hff)
		else $error("set register changed flags");

	mult_seen_c: cover property (go && op_code == afce_pkg::op_mult_signed_unsigned);
	call_seen_c: cover property (go && op_code == afce_pkg::op_relative_call ##3 done);
	interrupt_return_seen_c: cover property (go && op_code == afce_pkg::op_interrupt_return);
	back_to_back_c: cover property (done ##1 done);
endmodule

// ==== tb/tb_alu_and_flow_control_exec.sv ====
// self-checking testbench for the execution unit
`timescale 1ns/1ns
module tb_alu_and_flow_control_exec;
	logic clk;
	logic rst_b;
	logic op_valid;
	afce_pkg::afce_op_e op_code;
	logic [7:0] op_dst;
	logic [7:0] op_dst_hi;
	logic [7:0] op_src;
	logic [7:0] op_imm;
	logic [15:0] op_addr;
	logic [15:0] z_ptr;
	logic [15:0] stack_rdata;
	logic busy;
	logic done;
	logic wr_en;
	logic wr_pair;
	logic wr_r10;
	logic [15:0] wr_data;
	logic [7:0] sreg;
	logic [15:0] pc;
	logic stack_push;
	logic [15:0] stack_wdata;
	logic stack_pop;
	int n_errors = 0;
	int cmp_count = 0;
	logic [15:0] epc = 16'h0000;

	afce_exec afce_exec_i (.clk(clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
		.op_dst(op_dst), .op_dst_hi(op_dst_hi), .op_src(op_src), .op_imm(op_imm),
		.op_addr(op_addr), .z_ptr(z_ptr), .stack_rdata(stack_rdata), .busy(busy), .done(done),
		.wr_en(wr_en), .wr_pair(wr_pair), .wr_r10(wr_r10), .wr_data(wr_data), .sreg(sreg),
		.pc(pc), .stack_push(stack_push), .stack_wdata(stack_wdata), .stack_pop(stack_pop));

	initial clk = 1'b0;
	always #2 clk = ~clk;

	// =============================================================
	// compare, verdict and operation tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// opd packs {dst, dst_hi, src, imm}; cw packs {cycles, wr_en, wr_pair, wr_r10}
	task automatic run(input afce_pkg::afce_op_e op, input logic [31:0] opd,
		input logic [15:0] ad, input logic [5:0] cw, input logic [15:0] ed,
		input logic [7:0] es, input logic [15:0] ep);
		int n;
		int pushes;
		int pops;
		logic [15:0] pw;
		logic [15:0] ew;
		logic is_call;
		logic is_ret;
		is_call = op inside {afce_pkg::op_relative_call, afce_pkg::op_pointer_call,
			afce_pkg::op_absolute_call};
		is_ret = op inside {afce_pkg::op_subroutine_return, afce_pkg::op_interrupt_return};
		ew = epc + ((op == afce_pkg::op_absolute_call) ? 16'h0002 : 16'h0001);
		op_code = op;
		{op_dst, op_dst_hi, op_src, op_imm} = opd;
		op_addr = ad;
		z_ptr = ad + 16'h1000;
		stack_rdata = ad + 16'h2000;
		op_valid = 1'b1;
		n = 0;
		pushes = 0;
		pops = 0;
		pw = 16'h0000;
		do begin
			@(posedge clk);
			#1;
			n++;
			chk({15'h0000, busy}, {15'h0000, n < int'(cw[5:3])});
			if (stack_push === 1'b1) begin
				pushes++;
				pw = stack_wdata;
			end
			if (stack_pop === 1'b1)
				pops++;
			// offer a stray op while busy: it must be ignored
			if (done !== 1'b1) begin
				op_code = afce_pkg::op_add;
				op_dst = 8'h33;
			end
		end while (done !== 1'b1 && n < 8);
		chk(16'(n), {13'h0000, cw[5:3]});
		chk({15'h0000, wr_en}, {15'h0000, cw[2]});
		if (cw[2]) begin
			chk({14'h0000, wr_pair, wr_r10}, {14'h0000, cw[1:0]});
			chk(wr_data, ed);
		end
		chk({8'h00, sreg}, {8'h00, es});
		chk(pc, ep);
		chk(16'(pushes), {15'h0000, is_call});
		if (is_call)
			chk(pw, ew);
		chk(16'(pops), {15'h0000, is_ret});
		epc = ep;
	endtask

	// =============================================================
	// watchdog
	initial begin
		#20000;
		n_errors++;
		$display("watchdog expired");
		end_sim();
	end

	// =============================================================
	// main sequence
	initial begin
		rst_b = 1'b0;
		op_valid = 1'b0;
		op_code = afce_pkg::op_add;
		{op_dst, op_dst_hi, op_src, op_imm} = 32'h00000000;
		op_addr = 16'h0000;
		z_ptr = 16'h0000;
		stack_rdata = 16'h0000;
		repeat (6) @(posedge clk);
		#1;
		rst_b = 1'b1;
		chk({8'h00, sreg}, 16'h0000);
		chk(pc, 16'h0000);
		chk({14'h0000, busy, done}, 16'h0000);
		@(posedge clk);
		#1;
		run(afce_pkg::op_add, 32'h0f000100, 16'h0, 6'h0c, 16'h0010, 8'h20, 16'h0001);
		run(afce_pkg::op_add, 32'h80008000, 16'h0, 6'h0c, 16'h0000, 8'h0b, 16'h0002);
		run(afce_pkg::op_add_carry, 32'h0e000000, 16'h0, 6'h0c, 16'h000f, 8'h00, 16'h0003);
		run(afce_pkg::op_sub_imm, 32'h00000001, 16'h0, 6'h0c, 16'h00ff, 8'h25, 16'h0004);
		run(afce_pkg::op_sub_regs_carry, 32'h10000f00, 16'h0, 6'h0c, 16'h0000, 8'h20,
			16'h0005);
		run(afce_pkg::op_sub_imm_carry, 32'h80000001, 16'h0, 6'h0c, 16'h007f, 8'h28,
			16'h0006);
		run(afce_pkg::op_word_add_imm, 32'hff7f0001, 16'h0, 6'h16, 16'h8000, 8'h2c, 16'h0007);
		run(afce_pkg::op_word_sub_imm, 32'h00000001, 16'h0, 6'h16, 16'hffff, 8'h35, 16'h0008);
		$display("test arithmetic done");
		run(afce_pkg::op_and_regs, 32'hf0008f00, 16'h0, 6'h0c, 16'h0080, 8'h35, 16'h0009);
		run(afce_pkg::op_bitwise_conj_imm, 32'h0f0000f0, 16'h0, 6'h0c, 16'h0000, 8'h33,
			16'h000a);
		run(afce_pkg::op_or_regs, 32'h01008000, 16'h0, 6'h0c, 16'h0081, 8'h35, 16'h000b);
		run(afce_pkg::op_bitwise_disj_imm, 32'h00000000, 16'h0, 6'h0c, 16'h0000, 8'h33,
			16'h000c);
		run(afce_pkg::op_set_mask_bits, 32'h01000080, 16'h0, 6'h0c, 16'h0081, 8'h35,
			16'h000d);
		run(afce_pkg::op_clear_mask_bits, 32'hff0000ff, 16'h0, 6'h0c, 16'h0000, 8'h33,
			16'h000e);
		run(afce_pkg::op_test_reg, 32'h80000000, 16'h0, 6'h0c, 16'h0080, 8'h35, 16'h000f);
		run(afce_pkg::op_bitwise_xor_regs, 32'h5a00ff00, 16'h0, 6'h0c, 16'h00a5, 8'h35,
			16'h0010);
		run(afce_pkg::op_clear_reg, 32'h5a000000, 16'h0, 6'h0c, 16'h0000, 8'h33, 16'h0011);
		run(afce_pkg::op_set_reg_ones, 32'h12000000, 16'h0, 6'h0c, 16'h00ff, 8'h33,
			16'h0012);
		run(afce_pkg::op_ones_complement, 32'h0f000000, 16'h0, 6'h0c, 16'h00f0, 8'h35,
			16'h0013);
		run(afce_pkg::op_twos_complement, 32'h01000000, 16'h0, 6'h0c, 16'h00ff, 8'h35,
			16'h0014);
		run(afce_pkg::op_increment_reg, 32'h7f000000, 16'h0, 6'h0c, 16'h0080, 8'h3d,
			16'h0015);
		run(afce_pkg::op_decrement_reg, 32'h01000000, 16'h0, 6'h0c, 16'h0000, 8'h33,
			16'h0016);
		$display("test logic done");
		run(afce_pkg::op_mult_unsigned, 32'hff00ff00, 16'h0, 6'h17, 16'hfe01, 8'h31,
			16'h0017);
		run(afce_pkg::op_mult_signed, 32'hff000200, 16'h0, 6'h17, 16'hfffe, 8'h31, 16'h0018);
		run(afce_pkg::op_mult_signed_unsigned, 32'h80000200, 16'h0, 6'h17, 16'hff00, 8'h31,
			16'h0019);
		run(afce_pkg::op_frac_mult_unsigned, 32'h80008000, 16'h0, 6'h17, 16'h8000, 8'h30,
			16'h001a);
		run(afce_pkg::op_frac_mult_signed, 32'hc0004000, 16'h0, 6'h17, 16'he000, 8'h31,
			16'h001b);
		run(afce_pkg::op_frac_mult_mixed, 32'h80000100, 16'h0, 6'h17, 16'hff00, 8'h31,
			16'h001c);
		$display("test multiply done");
		run(afce_pkg::op_relative_jump, 32'h0, 16'h0010, 6'h10, 16'h0, 8'h31, 16'h002d);
		run(afce_pkg::op_pointer_jump, 32'h0, 16'h0000, 6'h10, 16'h0, 8'h31, 16'h1000);
		run(afce_pkg::op_absolute_jump, 32'h0, 16'h0200, 6'h18, 16'h0, 8'h31, 16'h0200);
		run(afce_pkg::op_relative_call, 32'h0, 16'hfffe, 6'h18, 16'h0, 8'h31, 16'h01ff);
		run(afce_pkg::op_pointer_call, 32'h0, 16'h0000, 6'h18, 16'h0, 8'h31, 16'h1000);
		run(afce_pkg::op_absolute_call, 32'h0, 16'h0400, 6'h20, 16'h0, 8'h31, 16'h0400);
		run(afce_pkg::op_subroutine_return, 32'h0, 16'h0123, 6'h20, 16'h0, 8'h31, 16'h2123);
		run(afce_pkg::op_interrupt_return, 32'h0, 16'h0456, 6'h20, 16'h0, 8'hb1, 16'h2456);
		$display("test flow done");
		run(afce_pkg::op_sub, 32'h05000300, 16'h0, 6'h0c, 16'h0002, 8'h90, 16'h2457);
		$display("test subtract done");
		op_valid = 1'b0;
		end_sim();
	end
endmodule
